// ### verilog/abx_exec.sv
`timescale 1ns/10ps
`default_nettype none
module abx_exec import abx_pkg::*; #(
   parameter int AW = ADDR_W,
   parameter int DW = DATA_W
) (
   input wire logic REF_CLK_IN,
   input wire logic RESET_IN,
   input wire logic INSTR_VALID_IN,
   input wire abx_instr_t INSTR_IN,
   output logic [DW-1:0] ACC_OUT,
   output abx_flags_t FLAGS_OUT,
   output logic SKIP_OUT,
   output logic NOP_CYCLE_OUT,
   output logic [DW-1:0] WR_DATA_OUT,
   output logic [AW-1:0] WR_ADDR_OUT,
   output logic WR_EN_OUT
);
   logic [DW-1:0] acc_r, acc_nxt;
   abx_flags_t flags_r, flags_nxt;
   logic skip_r, nop_cycle_r;
   logic [DW-1:0] wr_data_r;
   logic [AW-1:0] wr_addr_r;
   logic wr_en_r;
   logic [DW-1:0] freg;
   logic [AW-1:0] rd_addr;

   // file register storage, read in the executing cycle
   abx_regfile #(.AW(AW), .DW(DW)) u_regfile (
      .clk_in(REF_CLK_IN),
      .wr_en_in(wr_en_r),
      .wr_addr_in(wr_addr_r),
      .wr_data_in(wr_data_r),
      .rd_addr_in(rd_addr),
      .rd_data_out(freg)
   );

   // a write still pending from last cycle is forwarded to the read;
   // the store only takes it on the next edge, so without this bypass a
   // back-to-back op on the same register would see the stale byte
   wire fwd = wr_en_r && (wr_addr_r == INSTR_IN.faddr);
   assign rd_addr = INSTR_IN.faddr;
   wire [DW-1:0] fval = fwd ? wr_data_r : freg;

   // instruction is squashed to a no-operation after a taken skip;
   // squashing here gates every decode but the write-data select, so the discarded slot can touch
   // neither the accumulator, the flags nor the file register
   wire exec = INSTR_VALID_IN && !skip_r;
   wire op_add_lit = exec && (INSTR_IN.op == ABX_OP_ADD_LIT);
   wire op_add_reg = exec && (INSTR_IN.op == ABX_OP_ADD_REG);
   wire op_and_reg = exec && (INSTR_IN.op == ABX_OP_AND_REG);
   wire op_and_lit = exec && (INSTR_IN.op == ABX_OP_AND_LIT);
   wire op_bit_clr = exec && (INSTR_IN.op == ABX_OP_BIT_CLR);
   wire op_bit_set = exec && (INSTR_IN.op == ABX_OP_BIT_SET);
   wire op_skip_s = exec && (INSTR_IN.op == ABX_OP_SKIP_SET);
   wire op_skip_c = exec && (INSTR_IN.op == ABX_OP_SKIP_CLR);
   wire op_clr = exec && (INSTR_IN.op == ABX_OP_CLR_REG);

   // adder operand: literal or file register; a single adder serves
   // both add forms, the nibble sum is kept apart only for digit carry
   wire [DW-1:0] add_b = op_add_lit ? INSTR_IN.literal : fval;
   wire [DW:0] sum = {1'b0, acc_r} + {1'b0, add_b};
   wire [4:0] low_sum = {1'b0, acc_r[3:0]} + {1'b0, add_b[3:0]};
   wire [DW-1:0] and_b = op_and_lit ? INSTR_IN.literal : fval;
   wire [DW-1:0] and_res = acc_r & and_b;
   wire [DW-1:0] bit_mask = {{(DW-1){1'b0}}, 1'b1} << INSTR_IN.bit_idx;
   wire tested = fval[INSTR_IN.bit_idx];

   // byte result and where it goes
   wire is_add = op_add_lit || op_add_reg;
   wire is_and = op_and_lit || op_and_reg;
   wire [DW-1:0] byte_res = is_add ? sum[DW-1:0] : and_res;
   // zero detect as a per-lane or chain over the byte result
   logic [DW:0] nz_chain;
   assign nz_chain[0] = 1'b0;
   for (genvar j = 0; j < DW; j++) begin : g_zero_lane
      assign nz_chain[j+1] = nz_chain[j] | byte_res[j];
   end
   wire byte_zero = !nz_chain[DW];
   wire byte_to_reg = (op_add_reg || op_and_reg)
                      && (INSTR_IN.dest == DEST_REG);
   wire byte_to_acc = (is_add || is_and) && !byte_to_reg;

   // skip decision: set polarity and clear polarity
   wire skip_take = (op_skip_s && tested) || (op_skip_c && !tested);

   // accumulator and flag next values; flags not named by an op keep
   // their value, which is how bit ops and skips leave status alone
   always_comb begin
      acc_nxt = byte_to_acc ? byte_res : acc_r;
      flags_nxt = flags_r;
      if (is_add) begin
         flags_nxt.carry = sum[CARRY_BIT + 1];
         flags_nxt.digit_carry_flag = low_sum[DIGIT_BIT + 1];
      end
      if (is_add || is_and) begin
         flags_nxt.zero = byte_zero;
      end else if (op_clr) begin
         flags_nxt.zero = 1'b1;
      end
   end

   // file register write selection; bit ops leave flags alone
   wire wr_nxt = byte_to_reg || op_bit_clr || op_bit_set || op_clr;
   logic [DW-1:0] wdata_nxt;
   logic [DW-1:0] bclr_val;
   logic [DW-1:0] bset_val;

   // per-bit read-modify-write: only the indexed lane is touched, the
   // other lanes carry the forwarded operand so a bit op right after a
   // write to the same register builds on that write
   for (genvar i = 0; i < DW; i++) begin : g_bit_lane
      wire lane_hit = bit_mask[i];
      assign bclr_val[i] = lane_hit ? 1'b0 : fval[i];
      assign bset_val[i] = lane_hit ? 1'b1 : fval[i];
   end

   // write data by operation; byte ops bound for the accumulator still
   // form a value here, but the write strobe stays low for them
   always_comb begin
      case (INSTR_IN.op)
         ABX_OP_BIT_CLR: begin
            wdata_nxt = bclr_val;
         end
         ABX_OP_BIT_SET: begin
            wdata_nxt = bset_val;
         end
         ABX_OP_CLR_REG: begin
            wdata_nxt = CLEAR_VALUE;
         end
         default: begin
            wdata_nxt = byte_res;
         end
      endcase
   end

   // accumulator and status flags
   always_ff @(posedge REF_CLK_IN) begin
      if (RESET_IN) begin
         acc_r <= ACC_RESET;
         flags_r <= FLAGS_RESET;
      end else begin
         acc_r <= acc_nxt;
         flags_r <= flags_nxt;
      end
   end

   // skip pending flag, held until the squashed slot has been consumed;
   // a taken skip wins over the clear in the same cycle
   always_ff @(posedge REF_CLK_IN) begin
      if (RESET_IN) begin
         skip_r <= 1'b0;
         nop_cycle_r <= 1'b0;
      end else begin
         if (skip_take) begin
            skip_r <= 1'b1;
         end else if (INSTR_VALID_IN) begin
            skip_r <= 1'b0;
         end
         nop_cycle_r <= INSTR_VALID_IN && skip_r;
      end
   end

   // write port toward the file register store and the output pins;
   // address and data follow every slot, only the strobe qualifies them
   always_ff @(posedge REF_CLK_IN) begin
      if (RESET_IN) begin
         wr_en_r <= 1'b0;
         wr_addr_r <= '0;
         wr_data_r <= '0;
      end else begin
         wr_en_r <= wr_nxt;
         wr_addr_r <= INSTR_IN.faddr;
         wr_data_r <= wdata_nxt;
      end
   end

   // outputs straight from flip-flops, so the core sees no decode glitch
   // on its status or write strobe
   assign ACC_OUT = acc_r;
   assign FLAGS_OUT = flags_r;
   assign SKIP_OUT = skip_r;
   assign NOP_CYCLE_OUT = nop_cycle_r;
   assign WR_DATA_OUT = wr_data_r;
   assign WR_ADDR_OUT = wr_addr_r;
   assign WR_EN_OUT = wr_en_r;
endmodule // abx_exec
`default_nettype wire

// ### shared/abx_pkg.sv
package abx_pkg;
   localparam int ADDR_W = 7;
   localparam int DATA_W = 8;
   localparam int BIT_W = 3;
   localparam logic [6:0] FREG_ADDR_MIN = 7'h00;
   localparam logic [6:0] FREG_ADDR_MAX = 7'h7F;
   localparam logic [7:0] ACC_RESET = 8'h00;
   localparam logic [7:0] CLEAR_VALUE = 8'h00;
   localparam logic [2:0] FLAGS_RESET = 3'h0;
   localparam int CARRY_BIT = 7;
   localparam int DIGIT_BIT = 3;
   localparam int SKIP_CYCLES = 2;
   localparam logic DEST_ACC = 1'b0;
   localparam logic DEST_REG = 1'b1;

   typedef enum logic [3:0] {
      ABX_OP_NONE = 4'h0,
      ABX_OP_ADD_LIT = 4'h1,
      ABX_OP_ADD_REG = 4'h2,
      ABX_OP_AND_REG = 4'h3,
      ABX_OP_AND_LIT = 4'h4,
      ABX_OP_BIT_CLR = 4'h5,
      ABX_OP_BIT_SET = 4'h6,
      ABX_OP_SKIP_SET = 4'h7,
      ABX_OP_SKIP_CLR = 4'h8,
      ABX_OP_CLR_REG = 4'h9
   } abx_op_t;

   typedef struct packed {
      abx_op_t op;
      logic dest;
      logic [6:0] faddr;
      logic [2:0] bit_idx;
      logic [7:0] literal;
   } abx_instr_t;

   typedef struct packed {
      logic carry;
      logic digit_carry_flag;
      logic zero;
   } abx_flags_t;
endpackage

// ### verilog/abx_regfile.sv
`timescale 1ns/10ps
`default_nettype none
// file register store: combinational read so the executing op sees the
// operand in its own cycle, registered write on the following edge
module abx_regfile import abx_pkg::*; #(
   parameter int AW = ADDR_W,
   parameter int DW = DATA_W
) (
   input wire logic clk_in,
   input wire logic wr_en_in,
   input wire logic [AW-1:0] wr_addr_in,
   input wire logic [DW-1:0] wr_data_in,
   input wire logic [AW-1:0] rd_addr_in,
   output logic [DW-1:0] rd_data_out
);
   logic [DW-1:0] mem [0:(1<<AW)-1];

   // write port
   always_ff @(posedge clk_in) begin
      if (wr_en_in) begin
         mem[wr_addr_in] <= wr_data_in;
      end
   end

   assign rd_data_out = mem[rd_addr_in];
endmodule // abx_regfile
`default_nettype wire

// ### verif/abx_exec_sva.sv
`timescale 1ns/10ps
`default_nettype none
// port-level checks; a slot counts only when no skip is pending
module abx_exec_sva import abx_pkg::*; (
   input wire logic REF_CLK_IN,
   input wire logic RESET_IN,
   input wire logic INSTR_VALID_IN,
   input wire abx_instr_t INSTR_IN,
   input wire logic [7:0] ACC_OUT,
   input wire abx_flags_t FLAGS_OUT,
   input wire logic SKIP_OUT,
   input wire logic NOP_CYCLE_OUT,
   input wire logic [7:0] WR_DATA_OUT,
   input wire logic [6:0] WR_ADDR_OUT,
   input wire logic WR_EN_OUT
);
   default clocking @(posedge REF_CLK_IN); endclocking
   default disable iff (RESET_IN);
   // expected sums formed before the edge that executes the op
   wire logic go = INSTR_VALID_IN && !SKIP_OUT;
   wire abx_op_t op = INSTR_IN.op;
   wire logic [8:0] sum = {1'b0, ACC_OUT} + {1'b0, INSTR_IN.literal};
   wire logic [4:0] nib = {1'b0, ACC_OUT[3:0]}
                          + {1'b0, INSTR_IN.literal[3:0]};
   wire logic dcy = nib[4];
   wire logic [7:0] andl = ACC_OUT & INSTR_IN.literal;
   AST_ADD_LIT: assert property (go && op == ABX_OP_ADD_LIT |=>
      {FLAGS_OUT.carry, ACC_OUT} == $past(sum) && !WR_EN_OUT)
      else $error("add");
   AST_DIGIT: assert property (go && op == ABX_OP_ADD_LIT |=>
      FLAGS_OUT.digit_carry_flag == $past(dcy)) else $error("digit carry");
   AST_AND_LIT: assert property (go && op == ABX_OP_AND_LIT |=>
      ACC_OUT == $past(andl) && $stable(FLAGS_OUT.carry)) else $error("and");
   AST_ZERO: assert property (
      go && op inside {ABX_OP_ADD_LIT, ABX_OP_AND_LIT}
      |=> FLAGS_OUT.zero == (ACC_OUT == 8'h00)) else $error("zero flag");
   AST_CLR: assert property (
      go && op == ABX_OP_CLR_REG |=> WR_EN_OUT &&
      WR_DATA_OUT == CLEAR_VALUE && FLAGS_OUT.zero) else $error("clear");
   AST_BIT_SET: assert property (
      go && op == ABX_OP_BIT_SET |=> WR_EN_OUT &&
      WR_DATA_OUT[$past(INSTR_IN.bit_idx)] && $stable(FLAGS_OUT))
      else $error("set");
   AST_BIT_CLR: assert property (
      go && op == ABX_OP_BIT_CLR |=> WR_EN_OUT &&
      !WR_DATA_OUT[$past(INSTR_IN.bit_idx)] && $stable(FLAGS_OUT))
      else $error("clr");
   AST_DEST_REG: assert property (
      go && op == ABX_OP_ADD_REG && INSTR_IN.dest
      |=> WR_EN_OUT && $stable(ACC_OUT) &&
      WR_ADDR_OUT == $past(INSTR_IN.faddr))
      else $error("dest reg");
   AST_DEST_ACC: assert property (
      go && op == ABX_OP_AND_REG && !INSTR_IN.dest
      |=> !WR_EN_OUT) else $error("dest acc");
   AST_SQUASH: assert property (
      INSTR_VALID_IN && SKIP_OUT |=> NOP_CYCLE_OUT &&
      !SKIP_OUT && !WR_EN_OUT && $stable(ACC_OUT)) else $error("squash");
   cover property (INSTR_VALID_IN && SKIP_OUT);
   cover property (go && op == ABX_OP_ADD_LIT ##1 FLAGS_OUT.carry);
   cover property (go && op == ABX_OP_CLR_REG);
endmodule // abx_exec_sva
bind abx_exec abx_exec_sva chk_u (.REF_CLK_IN, .RESET_IN, .INSTR_VALID_IN,
   .INSTR_IN, .ACC_OUT, .FLAGS_OUT, .SKIP_OUT, .NOP_CYCLE_OUT, .WR_DATA_OUT,
   .WR_ADDR_OUT, .WR_EN_OUT);
`default_nettype wire

// ### verif/test_abx_exec.sv
`timescale 1ns/10ps
`default_nettype none
module test_abx_exec import abx_pkg::*;;
   logic clk = 1'b0, rst = 1'b1, vld = 1'b0, sk, no_operation, we;
   abx_instr_t ins = '0;
   abx_flags_t fl;
   logic [7:0] acc, wd;
   logic [6:0] wa;
   int failures = 0, comparisons = 0;
   abx_exec dut_u (.REF_CLK_IN(clk), .RESET_IN(rst), .INSTR_VALID_IN(vld),
      .INSTR_IN(ins), .ACC_OUT(acc), .FLAGS_OUT(fl), .SKIP_OUT(sk),
      .NOP_CYCLE_OUT(no_operation), .WR_DATA_OUT(wd), .WR_ADDR_OUT(wa), .WR_EN_OUT(we));
   // 8 ns core clock
   initial begin
      forever #4 clk = ~clk;
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // one slot then an idle cycle, so every result is read settled
   task automatic send(input abx_op_t op, input logic [7:0] k = 8'h00,
      input logic [2:0] b = 3'h0, input logic d = DEST_REG);
      @(posedge clk);
      vld <= 1'b1;
      ins <= '{op, d, 7'h7F, b, k};
      @(posedge clk);
      vld <= 1'b0;
      #1;
   endtask
   // flags packed as carry, digit carry, zero
   task automatic exp_af(input logic [7:0] a, input logic [2:0] f);
      chk(acc, a);
      chk({5'h00, fl}, {5'h00, f});
   endtask
   task automatic exp_wr(input logic [7:0] d);
      chk({we, wa}, 8'hFF);
      chk(wd, d);
   endtask
   task automatic t_reset;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      #1;
      exp_af(ACC_RESET, FLAGS_RESET);
      chk({5'h00, sk, no_operation, we}, 8'h00);
   endtask
   task automatic t_lit;
      send(ABX_OP_ADD_LIT, 8'hF9);
      exp_af(8'hF9, 3'h0);
      send(ABX_OP_AND_LIT, 8'h0F);
      exp_af(8'h09, 3'h0);
      send(ABX_OP_ADD_LIT, 8'hF7);
      exp_af(8'h00, 3'h7);
      send(ABX_OP_AND_LIT, 8'h00);
      exp_af(8'h00, 3'h7);
      send(ABX_OP_ADD_LIT, 8'h3C);
      exp_af(8'h3C, 3'h0);
   endtask
   // file register 7Fh is built up from a cleared value
   task automatic t_reg;
      send(ABX_OP_CLR_REG);
      exp_wr(8'h00);
      exp_af(8'h3C, 3'h1);
      send(ABX_OP_ADD_REG);
      exp_wr(8'h3C);
      send(ABX_OP_ADD_REG, , , DEST_ACC);
      exp_af(8'h78, 3'h2);
      send(ABX_OP_AND_REG, , , DEST_ACC);
      exp_af(8'h38, 3'h2);
      send(ABX_OP_BIT_CLR, , 3'h2);
      exp_wr(8'h38);
      send(ABX_OP_BIT_SET, , 3'h7);
      exp_wr(8'hB8);
      send(ABX_OP_AND_REG);
      exp_wr(8'h38);
   endtask
   // register now 38h: bit 3 set, bits 0 and 7 clear
   task automatic t_skip;
      send(ABX_OP_SKIP_SET, , 3'h3);
      chk({7'h00, sk}, 8'h01);
      send(ABX_OP_ADD_LIT, 8'h01);
      chk({7'h00, no_operation}, 8'h01);
      send(ABX_OP_SKIP_SET, , 3'h7);
      send(ABX_OP_ADD_LIT, 8'h01);
      exp_af(8'h39, 3'h0);
      send(ABX_OP_SKIP_CLR, , 3'h0);
      send(ABX_OP_ADD_LIT, 8'h01);
      exp_af(8'h39, 3'h0);
      send(ABX_OP_SKIP_CLR, , 3'h5);
      chk({7'h00, sk}, 8'h00);
   endtask
   task automatic finish_test;
      $display("comparisons=%0d failures=%0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   initial begin
      t_reset;
      t_lit;
      t_reg;
      t_skip;
      finish_test;
   end
endmodule // test_abx_exec
`default_nettype wire
